/* File: dv/amdsu_seq_model.sv */
`timescale 1ns/100ps
// Sequencer stand-in: offers one fetched instruction and waits for its result pulse
module amdsu_seq_model (
   input  wire logic               clk_sys,     // Processor clock
   input  wire logic               instr_ready, // Block can take an instruction
   input  wire logic               instr_done,  // Result pulse from the block
   output logic                    instr_valid, // Instruction offered
   output amdsu_pkg::amdsu_instr_s instr        // Instruction and operand
);
   import amdsu_pkg::*;

   // Idle before the first request
   initial begin
      instr_valid = 1'b0;
      instr       = '0;
   end

   // Any opcode and operand given are offered as they stand, including non-real constants and zero divisors
   task automatic issue(input amdsu_op_e op, input logic [31:0] opnd, input logic ind,
                        input logic ok, output bit seen);
      @(posedge clk_sys);
      instr_valid <= 1'b1;
      instr       <= '{op: op, operand: opnd, indirect: ind, ptr_ok: ok};
      // Hold until an edge sees ready high
      do @(posedge clk_sys); while (instr_ready !== 1'b1);
      instr_valid <= 1'b0;
      // Released operand shows the inverse, never the last value; op and pointer bits keep their last value
      instr.operand <= ~opnd;
      seen = 1'b0;
      // Bounded wait for the result pulse
      repeat (3) begin
         #1;
         if (instr_done === 1'b1) seen = 1'b1;
         if (!seen) @(posedge clk_sys);
      end
   endtask : issue

endmodule : amdsu_seq_model

/* File: dv/amdsu_top_test.sv */
`timescale 1ns/100ps
// Self-checking bench for the accumulator datapath
module amdsu_top_test;
   import amdsu_pkg::*;

   logic         clk_sys   = 1'b0;  // 125 MHz
   logic         arst_n    = 1'b0;  // Reset, active low
   logic         instr_valid;       // From sequencer model
   logic         instr_ready;       // From block
   logic         instr_done;        // Result pulse
   amdsu_instr_s instr;             // Instruction and operand
   logic [31:0]  acc_q;             // Accumulator
   amdsu_flags_s flags_q;           // Status flags
   logic [3:0]   reg_addr  = '0;    // Register address
   logic [31:0]  reg_wdata = '0;    // Register write data
   logic         reg_wr    = 1'b0;  // Write strobe
   logic         reg_rd    = 1'b0;  // Read strobe
   logic [31:0]  reg_rdata;         // Read data
   logic [31:0]  rv;                // Last value read
   int           n_fail    = 0;     // Mismatches
   int           n_tests   = 0;     // Comparisons
   int           cyc       = 0;     // Cycle count for the hang guard
   bit           seen;              // Result pulse observed

   // Clock, 8 ns period
   always #4 clk_sys = ~clk_sys;

   amdsu_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .instr_valid(instr_valid),
      .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done), .acc_q(acc_q),
      .flags_q(flags_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   amdsu_seq_model seq (.clk_sys(clk_sys), .instr_ready(instr_ready),
      .instr_done(instr_done), .instr_valid(instr_valid), .instr(instr));

   // Verdict and end of run
   task automatic stop_test;
      if (n_fail == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test

   // Compare and report
   task automatic chk(input string what, input logic [31:0] sv, input logic [31:0] ev);
      n_tests++;
      if (sv !== ev) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, ev, sv);
      end
   endtask : chk

   // One-cycle write strobe
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : reg_write

   // One-cycle read strobe, data taken in the following cycle only
   task automatic reg_read(input logic [3:0] a);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask : reg_read

   // Issue one instruction and expect its result pulse
   task automatic run(input amdsu_op_e op, input logic [31:0] opnd, input logic ok = 1'b1);
      seq.issue(op, opnd, !ok, ok, seen);
      chk("done", {31'h0, seen}, 32'h1);
      chk("ready", {31'h0, instr_ready}, 32'h1);
   endtask : run

   // Reset values, accumulator write, unmapped read
   task automatic t_regs;
      for (int i = 0; i < 4; i++) begin
         reg_read(4'(i * 4));
         chk("reset reg", rv, 32'h0);
      end
      reg_read(4'h2);
      chk("unmapped", rv, 32'h0);
      reg_write(AMDSU_OFS_ACC, 32'h1234_5678);
      reg_read(AMDSU_OFS_ACC);
      chk("acc write", rv, 32'h1234_5678);
      // Idle code is taken but gives no pulse and touches nothing
      seq.issue(op_idle, 32'h0000_0001, 1'b0, 1'b1, seen);
      chk("idle done", {31'h0, seen}, 32'h0);
      chk("idle acc", acc_q, 32'h1234_5678);
      chk("idle flags", {24'h0, flags_q}, 32'h0);
   endtask : t_regs

   // Both BCD multiplies, bad digit and zero result
   task automatic t_mul;
      run(bcd_multiply_wide_op, 32'h0000_0002);
      chk("wide mul acc", acc_q, 32'h2469_1356);
      chk("wide mul flags", {24'h0, flags_q}, 32'h0);
      reg_write(AMDSU_OFS_ACC, 32'h9999_9999);
      run(bcd_multiply_wide_op, 32'h0000_0002);
      chk("wide mul low", acc_q, 32'h9999_9998);
      reg_read(AMDSU_OFS_STACK);
      chk("wide mul high", rv, 32'h0000_0001);
      reg_read(AMDSU_OFS_DEPTH);
      chk("depth", rv, 32'h2);
      reg_write(AMDSU_OFS_ACC, 32'h5678_1234);
      run(bcd_multiply_op, 32'hffff_0002);
      chk("mul low half", acc_q, 32'h0000_2468);
      reg_write(AMDSU_OFS_ACC, 32'h0000_9999);
      run(bcd_multiply_op, 32'h0000_9999);
      chk("mul max", acc_q, 32'h9998_0001);
      run(bcd_multiply_op, 32'h0000_000a);
      chk("bad digit acc", acc_q, 32'h9998_0001);
      chk("bad digit flags", {24'h0, flags_q}, 32'h40);
      run(bcd_multiply_op, 32'h0);
      chk("zero acc", acc_q, 32'h0);
      chk("zero flags", {24'h0, flags_q}, 32'h01);
   endtask : t_mul

   // Divides, remainder push, zero divisor, flag hold across a real op
   task automatic t_div;
      reg_write(AMDSU_OFS_ACC, 32'h0000_0100);
      run(bcd_divide_op, 32'hffff_0003);
      chk("div quot", acc_q, 32'h33);
      reg_read(AMDSU_OFS_STACK);
      chk("div rem", rv, 32'h1);
      reg_write(AMDSU_OFS_ACC, 32'h1234_5678);
      run(bcd_divide_wide_op, 32'h0010_0000);
      chk("wide quot", acc_q, 32'h123);
      reg_read(AMDSU_OFS_STACK);
      chk("wide rem", rv, 32'h0004_5678);
      run(bcd_divide_op, 32'h0);
      chk("div0 acc", acc_q, 32'h123);
      reg_read(AMDSU_OFS_FLAGS);
      chk("div0 flags", rv, 32'h80);
      reg_write(AMDSU_OFS_ACC, 32'h4000_0000);
      run(real_multiply_op, 32'h4040_0000);
      chk("real mul", acc_q, 32'h40c0_0000);
      chk("range held", {24'h0, flags_q}, 32'h80);
   endtask : t_div

   // Real subtract, sign, pointer, non-real, overflow and underflow cases
   task automatic t_real;
      reg_write(AMDSU_OFS_ACC, 32'h3f80_0000);
      run(real_subtract_op, 32'h4040_0000);
      chk("sub", acc_q, 32'h4000_0000);
      run(real_subtract_op, 32'h3f80_0000);
      chk("sub neg", acc_q, 32'hbf80_0000);
      chk("neg flags", {24'h0, flags_q}, 32'h82);
      run(real_subtract_op, 32'h4040_0000, 1'b0);
      chk("ptr acc", acc_q, 32'hbf80_0000);
      chk("ptr flag", {31'h0, flags_q.invalid_pointer_flag}, 32'h1);
      run(real_multiply_op, 32'h7fc0_0000);
      chk("nonreal acc", acc_q, 32'hbf80_0000);
      chk("nonreal flag", {31'h0, flags_q.bad_digit_flag}, 32'h1);
      reg_write(AMDSU_OFS_ACC, 32'h7f7f_ffff);
      run(real_subtract_op, 32'hff7f_ffff);
      chk("sign flag", {31'h0, flags_q.sign_error_flag}, 32'h1);
      chk("ovf acc", acc_q, 32'hff80_0000);
      chk("inv float", {31'h0, flags_q.invalid_float_flag}, 32'h1);
      reg_write(AMDSU_OFS_ACC, 32'h0080_0000);
      run(real_multiply_op, 32'h3f00_0000);
      chk("under acc", acc_q, 32'h0);
      chk("under flag", {31'h0, flags_q.underflow_flag}, 32'h1);
   endtask : t_real

   // Mid-run reset clears accumulator, flags and stack depth
   task automatic t_reset;
      reg_write(AMDSU_OFS_ACC, 32'h0000_0042);
      @(posedge clk_sys);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("reset acc", acc_q, 32'h0);
      chk("reset flags", {24'h0, flags_q}, 32'h0);
      reg_read(AMDSU_OFS_DEPTH);
      chk("reset depth", rv, 32'h0);
   endtask : t_reset

   // Hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         stop_test;
      end
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_regs;
      t_mul;
      t_div;
      t_real;
      t_reset;
      stop_test;
   end

endmodule : amdsu_top_test

/* File: src/amdsu_bcd2bin.sv */
`timescale 1ns/100ps
// Packed BCD to binary, with a per-digit validity check
module amdsu_bcd2bin #(
   parameter int DIGITS = 8                    // Decimal digits handled
) (
   input  wire logic [4*DIGITS-1:0] bcd_i,    // BCD value, digit 0 in low nibble
   output logic      [4*DIGITS-1:0] bin_o,    // Binary value
   output logic                     bad_o     // Some nibble is above nine
);

   logic [4*DIGITS-1:0] part [DIGITS+1];      // Horner partial sums
   logic [DIGITS-1:0]   bad_dig;              // Per-digit invalid marks

   assign part[0] = '0;

   // Horner chain from the top digit down; times ten as two shifts
   for (genvar i = 0; i < DIGITS; i++) begin : g_dig
      logic [3:0] nib;                         // Digit taken this stage
      assign nib        = bcd_i[4*(DIGITS-1-i) +: 4];
      assign bad_dig[i] = (nib > 4'h9);
      assign part[i+1]  = (part[i] << 3) + (part[i] << 1)
                          + {{(4*DIGITS-4){1'b0}}, nib};
   end

   assign bin_o = part[DIGITS];
   assign bad_o = |bad_dig;

endmodule : amdsu_bcd2bin

/* File: src/amdsu_pkg.sv */
package amdsu_pkg;

   // Instruction codes handed over by the sequencer
   typedef enum logic [2:0] {
      op_idle              = 3'b000,
      real_subtract_op     = 3'b001,
      bcd_multiply_op      = 3'b010,
      bcd_multiply_wide_op = 3'b011,
      real_multiply_op     = 3'b100,
      bcd_divide_op        = 3'b101,
      bcd_divide_wide_op   = 3'b110
   } amdsu_op_e;

   // One instruction with its fetched operand
   typedef struct packed {
      amdsu_op_e   op;       // Operation
      logic [31:0] operand;  // Constant or two data words, low word in [15:0]
      logic        indirect; // Operand was reached through a pointer
      logic        ptr_ok;   // Pointer referenced a valid data address
   } amdsu_instr_s;

   // Discrete status flags, bit order fixed for the flag register
   typedef struct packed {
      logic divide_range_flag;
      logic bad_digit_flag;
      logic underflow_flag;
      logic sign_error_flag;
      logic invalid_float_flag;
      logic invalid_pointer_flag;
      logic negative_flag;
      logic zero_flag;
   } amdsu_flags_s;

   // Register offsets (byte addresses)
   localparam logic [3:0] AMDSU_OFS_ACC   = 4'h0;
   localparam logic [3:0] AMDSU_OFS_STACK = 4'h4;
   localparam logic [3:0] AMDSU_OFS_FLAGS = 4'h8;
   localparam logic [3:0] AMDSU_OFS_DEPTH = 4'hc;

   // Reset values
   localparam logic [31:0] AMDSU_ACC_RST   = 32'h0000_0000;
   localparam logic [7:0]  AMDSU_FLAGS_RST = 8'h00;

   // Float field constants
   localparam logic [7:0]  AMDSU_EXP_MAX  = 8'hff;
   localparam logic [9:0]  AMDSU_EXP_BIAS = 10'h07f;

   // Which flags each instruction family re-evaluates
   localparam logic [7:0] AMDSU_MASK_REAL = 8'h7f;
   localparam logic [7:0] AMDSU_MASK_MUL  = 8'h43;
   localparam logic [7:0] AMDSU_MASK_DIV  = 8'hc3;

endpackage : amdsu_pkg

/* File: src/amdsu_top.sv */
`timescale 1ns/100ps
module amdsu_top
   import amdsu_pkg::*;
#(
   parameter int STACK_DEPTH = 8               // Accumulator stack locations
) (
   input  wire logic         clk_sys,          // 125 MHz clock
   input  wire logic         arst_n,           // Async reset, active low
   input  wire logic         instr_valid,      // Instruction offered
   input  amdsu_pkg::amdsu_instr_s instr,      // Instruction and operand
   output logic              instr_ready,      // Always able to take one
   output logic              instr_done,       // Result stands, one pulse
   output logic [31:0]       acc_q,            // Accumulator
   output amdsu_pkg::amdsu_flags_s flags_q,    // Discrete status flags
   input  wire logic [3:0]   reg_addr,         // Register byte address
   input  wire logic [31:0]  reg_wdata,        // Write data
   input  wire logic         reg_wr,           // Write strobe
   input  wire logic         reg_rd,           // Read strobe
   output logic [31:0]       reg_rdata         // Read data, cycle after strobe
);
   import amdsu_pkg::*;

   // Reset release through two flops; assertion stays asynchronous
   logic rst_meta_ff;                           // First reset stage
   logic rst_n_ff;                              // Reset seen by the design
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   logic [31:0] acc_ff, nxt_acc;                // Accumulator
   logic [7:0]  flags_ff, nxt_flags;            // Flag bits
   logic [31:0] stack_ff [STACK_DEPTH];         // Accumulator stack
   logic [31:0] nxt_stack [STACK_DEPTH];
   logic [3:0]  depth_ff, nxt_depth;            // Filled stack locations
   logic        done_ff, nxt_done;              // Completion pulse
   logic [31:0] rdata_ff, nxt_rdata;            // Read data
   logic        wide_op;                        // 32-bit operand width
   logic [31:0] opd_bcd;                        // Operand trimmed to width
   logic [31:0] a_bin, o_bin;                   // Binary forms
   logic [15:0] a_lo_bin;                       // Low four accumulator digits
   logic        a_bad, o_bad, a_lo_bad;         // Digit checks
   logic [53:0] prod_bin;                       // Product in binary
   logic [63:0] prod_bcd;                       // Product in BCD
   logic [63:0] quot_bcd, rem_bcd;              // Divide results in BCD
   logic [32:0] fsub_res, fmul_res;             // Real results, {underflow, value}
   logic        fsub_ovf, fmul_ovf;             // Real result overflowed

   // 16-bit forms only look at the low data word
   assign wide_op = (instr.op == bcd_multiply_wide_op) || (instr.op == bcd_divide_wide_op);
   assign opd_bcd = wide_op ? instr.operand : {16'h0000, instr.operand[15:0]};

   // Digit decoders for accumulator and operand
   amdsu_bcd2bin #(.DIGITS(8)) u_acc (
      .bcd_i (acc_ff),
      .bin_o (a_bin),
      .bad_o (a_bad)
   );
   amdsu_bcd2bin #(.DIGITS(4)) u_acc_lo (
      .bcd_i (acc_ff[15:0]),
      .bin_o (a_lo_bin),
      .bad_o (a_lo_bad)
   );
   amdsu_bcd2bin #(.DIGITS(8)) u_opd (
      .bcd_i (opd_bcd),
      .bin_o (o_bin),
      .bad_o (o_bad)
   );

   // Binary to sixteen BCD digits by shift-and-add-three
   function automatic logic [63:0] bin2bcd(input logic [53:0] v);
      logic [63:0] d;
      d = '0;
      for (int i = 53; i >= 0; i--) begin
         for (int k = 0; k < 16; k++) begin
            if (d[4*k +: 4] > 4'h4) begin
               d[4*k +: 4] = d[4*k +: 4] + 4'h3;
            end
         end
         d = {d[62:0], v[i]};
      end
      return d;
   endfunction : bin2bcd

   // Single-precision multiply, truncating; denormals read as zero
   function automatic logic [33:0] fmul(input logic [31:0] a, input logic [31:0] b);
      logic        s;
      logic [47:0] p;
      logic [9:0]  e;
      logic [22:0] m;
      s = a[31] ^ b[31];
      p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - AMDSU_EXP_BIAS;
      m = p[47] ? p[46:24] : p[45:23];
      e = p[47] ? e + 10'd1 : e;
      if (a[30:23] == 8'h00 || b[30:23] == 8'h00) begin
         return {2'b00, s, 31'h0};
      end else if (e[9] || e == 10'd0) begin
         return {2'b01, s, 31'h0};
      end else if (e >= {2'b00, AMDSU_EXP_MAX}) begin
         return {2'b10, s, AMDSU_EXP_MAX, 23'h0};
      end
      return {2'b00, s, e[7:0], m};
   endfunction : fmul

   // Single-precision a - b, truncating; denormals read as zero
   function automatic logic [33:0] fsub(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] x, y, t;
      logic [26:0] mx, my, sm;
      logic [9:0]  e;
      logic [7:0]  d;
      logic        done;
      x = a;
      y = {~b[31], b[30:0]};
      if (y[30:0] > x[30:0]) begin
         t = x;
         x = y;
         y = t;
      end
      mx = (x[30:23] == 8'h00) ? 27'h0 : {2'b01, x[22:0], 2'b00};
      my = (y[30:23] == 8'h00) ? 27'h0 : {2'b01, y[22:0], 2'b00};
      d  = x[30:23] - y[30:23];
      my = (d > 8'd26) ? 27'h0 : (my >> d);
      sm = (x[31] == y[31]) ? mx + my : mx - my;
      e  = {2'b00, x[30:23]};
      done = 1'b0;
      if (sm[26]) begin
         sm = sm >> 1;
         e  = e + 10'd1;
      end
      for (int i = 0; i < 26; i++) begin
         if (!done && sm != 27'h0 && !sm[25]) begin
            sm = sm << 1;
            e  = e - 10'd1;
         end else begin
            done = 1'b1;
         end
      end
      if (sm == 27'h0 || x[30:23] == 8'h00) begin
         return {2'b00, 32'h0};
      end else if (e[9] || e == 10'd0) begin
         return {2'b01, x[31], 31'h0};
      end else if (e >= {2'b00, AMDSU_EXP_MAX}) begin
         return {2'b10, x[31], AMDSU_EXP_MAX, 23'h0};
      end
      return {2'b00, x[31], e[7:0], sm[24:2]};
   endfunction : fsub

   // Arithmetic results, all combinational from the current operands
   always_comb begin
      prod_bin = (instr.op == bcd_multiply_op) ? 54'(a_lo_bin) * 54'(o_bin[15:0])
                                                : 54'(a_bin) * 54'(o_bin);
      prod_bcd = bin2bcd(prod_bin);
      quot_bcd = bin2bcd((o_bin == 32'h0) ? 54'h0 : 54'(a_bin / o_bin));
      rem_bcd  = bin2bcd((o_bin == 32'h0) ? 54'h0 : 54'(a_bin % o_bin));
      {fsub_ovf, fsub_res} = fsub(instr.operand, acc_ff);
      {fmul_ovf, fmul_res} = fmul(acc_ff, instr.operand);
   end

   // Execute one instruction per cycle; flags outside its mask are kept
   always_comb begin
      logic        is_real;
      logic        push;
      logic [31:0] push_val;
      logic [7:0]  mask;
      amdsu_flags_s f;
      is_real  = 1'b0;
      push     = 1'b0;
      push_val = 32'h0;
      mask     = 8'h00;
      f        = '0;
      nxt_acc  = acc_ff;
      if (instr_valid) begin
         case (instr.op)
            real_subtract_op, real_multiply_op: begin
               is_real = 1'b1;
               mask    = AMDSU_MASK_REAL;
               if (instr.indirect && !instr.ptr_ok) begin
                  f.invalid_pointer_flag = 1'b1;
               end else if (instr.operand[30:23] == AMDSU_EXP_MAX
                            || acc_ff[30:23] == AMDSU_EXP_MAX) begin
                  f.bad_digit_flag = 1'b1;
               end else if (instr.op == real_subtract_op) begin
                  nxt_acc           = fsub_res[31:0];
                  f.underflow_flag  = fsub_res[32];
                  f.sign_error_flag = fsub_ovf;
               end else begin
                  nxt_acc          = fmul_res[31:0];
                  f.underflow_flag = fmul_res[32];
               end
            end
            bcd_multiply_op, bcd_multiply_wide_op: begin
               mask = AMDSU_MASK_MUL;
               if (o_bad || ((instr.op == bcd_multiply_op) ? a_lo_bad : a_bad)) begin
                  f.bad_digit_flag = 1'b1;
               end else begin
                  nxt_acc = prod_bcd[31:0];
                  if (instr.op == bcd_multiply_wide_op) begin
                     push     = 1'b1;
                     push_val = prod_bcd[63:32];
                  end
               end
            end
            bcd_divide_op, bcd_divide_wide_op: begin
               mask = AMDSU_MASK_DIV;
               if (o_bad || a_bad) begin
                  f.bad_digit_flag = 1'b1;
               end else if (o_bin == 32'h0) begin
                  f.divide_range_flag = 1'b1;
               end else begin
                  nxt_acc  = quot_bcd[31:0];
                  push     = 1'b1;
                  push_val = rem_bcd[31:0];
               end
            end
            default: begin
               mask = 8'h00;
            end
         endcase
      end
      // Result flags follow the value left in the accumulator
      f.zero_flag          = is_real ? (nxt_acc[30:0] == 31'h0) : (nxt_acc == 32'h0);
      f.negative_flag      = is_real && nxt_acc[31] && (nxt_acc[30:0] != 31'h0);
      f.invalid_float_flag = is_real && (nxt_acc[30:23] == AMDSU_EXP_MAX);
      nxt_flags = (flags_ff & ~mask) | (f & mask);
      // Software may load the accumulator; a same-cycle instruction wins
      if (reg_wr && reg_addr == AMDSU_OFS_ACC && mask == 8'h00) begin
         nxt_acc = reg_wdata;
      end
      // Push shifts the stack down; the deepest entry falls off
      nxt_stack = stack_ff;
      nxt_depth = depth_ff;
      if (push) begin
         nxt_stack[0] = push_val;
         for (int i = 1; i < STACK_DEPTH; i++) begin
            nxt_stack[i] = stack_ff[i-1];
         end
         nxt_depth = (depth_ff == 4'(STACK_DEPTH)) ? depth_ff : depth_ff + 4'd1;
      end
      nxt_done = instr_valid && (instr.op != op_idle);
   end

   // Register read mux; unmapped offsets read zero
   always_comb begin
      nxt_rdata = 32'h0;
      if (reg_rd) begin
         case (reg_addr)
            AMDSU_OFS_ACC:   nxt_rdata = acc_ff;
            AMDSU_OFS_STACK: nxt_rdata = stack_ff[0];
            AMDSU_OFS_FLAGS: nxt_rdata = {24'h0, flags_ff};
            AMDSU_OFS_DEPTH: nxt_rdata = {28'h0, depth_ff};
            default:         nxt_rdata = 32'h0;
         endcase
      end
   end

   // State registers
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         acc_ff   <= AMDSU_ACC_RST;
         flags_ff <= AMDSU_FLAGS_RST;
         depth_ff <= 4'h0;
         done_ff  <= 1'b0;
         rdata_ff <= 32'h0;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_ff[i] <= 32'h0;
         end
      end else begin
         acc_ff   <= nxt_acc;
         flags_ff <= nxt_flags;
         depth_ff <= nxt_depth;
         done_ff  <= nxt_done;
         rdata_ff <= nxt_rdata;
         stack_ff <= nxt_stack;
      end
   end

   assign instr_ready = 1'b1;   // Every operation completes in one cycle
   assign instr_done  = done_ff;
   assign acc_q       = acc_ff;
   assign flags_q     = amdsu_flags_s'(flags_ff);
   assign reg_rdata   = rdata_ff;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n_ff);

   logic real_done_ff;                          // Last result was a real op
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         real_done_ff <= 1'b0;
      end else begin
         real_done_ff <= instr_valid && (instr.op == real_subtract_op
                                         || instr.op == real_multiply_op);
      end
   end

   sequence s_div_zero;
      instr_valid && (instr.op == bcd_divide_op || instr.op == bcd_divide_wide_op)
      && !o_bad && !a_bad && o_bin == 32'h0;
   endsequence
   sequence s_bad_ptr;
      instr_valid && (instr.op == real_subtract_op || instr.op == real_multiply_op)
      && instr.indirect && !instr.ptr_ok;
   endsequence

   div_range_set_a: assert property (s_div_zero |=> flags_ff[7] && $stable(acc_ff))
      else $error("divide by zero did not flag range");
   bad_ptr_a: assert property (s_bad_ptr |=> flags_ff[2] && acc_ff == $past(acc_ff))
      else $error("bad pointer not flagged");
   zero_flag_a: assert property (instr_done |->
      flags_ff[0] == (real_done_ff ? acc_ff[30:0] == 31'h0 : acc_ff == 32'h0))
      else $error("zero flag disagrees with accumulator");
   neg_flag_a: assert property (instr_done && real_done_ff |->
      flags_ff[1] == (acc_ff[31] && acc_ff[30:0] != 31'h0))
      else $error("negative flag disagrees with accumulator");
   inv_float_a: assert property (instr_done && real_done_ff |->
      flags_ff[3] == (acc_ff[30:23] == AMDSU_EXP_MAX))
      else $error("invalid float flag wrong");
   wide_push_a: assert property (instr_valid && instr.op == bcd_multiply_wide_op
      && !o_bad && !a_bad |=> stack_ff[0] == $past(prod_bcd[63:32]))
      else $error("upper product digits not pushed");
   div_rem_a: assert property (instr_valid && instr.op == bcd_divide_op
      && !o_bad && !a_bad && o_bin != 32'h0 |=> stack_ff[0] == $past(rem_bcd[31:0])
      && acc_ff == $past(quot_bcd[31:0]))
      else $error("divide results misplaced");
   mul_keeps_a: assert property (instr_valid && instr.op == bcd_multiply_op
      |=> flags_ff[7] == $past(flags_ff[7])
      && flags_ff[5:2] == $past(flags_ff[5:2]))
      else $error("multiply touched flags it does not own");
   bad_digit_a: assert property (instr_valid && instr.op == bcd_multiply_op
      && o_bad |=> flags_ff[6] && $stable(acc_ff))
      else $error("bad digit not flagged");
   done_pulse_a: assert property (instr_valid && instr.op != op_idle
      |=> instr_done ##1 (instr_done == $past(instr_valid, 1)))
      else $error("completion pulse out of step");

endmodule : amdsu_top
